/* File: verilog/rac_defines.svh */
// Register offsets, field positions, reset values and divider taps of the alarm/clock-output block
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

// Register offsets
`define RAC_ADDR_MONTH      8'h07
`define RAC_ADDR_YEAR       8'h08
`define RAC_ADDR_MIN_ALARM  8'h09
`define RAC_ADDR_HOUR_ALARM 8'h0A
`define RAC_ADDR_DAY_ALARM  8'h0B
`define RAC_ADDR_WDAY_ALARM 8'h0C
`define RAC_ADDR_CLK_CTRL   8'h0D

// Field positions
`define RAC_CENTURY_BIT     7
`define RAC_ALARM_DIS_BIT   7
`define RAC_CLK_EN_BIT      7

// Writable-bit masks; masked bits read as zero
`define RAC_MONTH_MASK      8'h9F
`define RAC_YEAR_MASK       8'hFF
`define RAC_MIN_MASK        8'hFF
`define RAC_HOUR_MASK       8'hBF
`define RAC_DAY_MASK        8'hBF
`define RAC_WDAY_MASK       8'h87
`define RAC_CLK_CTRL_MASK   8'h83

// Reset values
`define RAC_MONTH_RESET     8'h01
`define RAC_YEAR_RESET      8'h00
`define RAC_ALARM_RESET     8'h80
`define RAC_CLK_CTRL_RESET  8'h80

// Oscillator divider: 32768 Hz source, taps for 1024 Hz, 32 Hz and 1 Hz
`define RAC_OSC_HZ          32768
`define RAC_DIV_W           15
`define RAC_TAP_1024HZ      4
`define RAC_TAP_32HZ        9
`define RAC_TAP_1HZ         14

`endif

/* File: verilog/rac_pkg.sv */
// Types shared by the alarm/clock-output block
package rac_pkg;

    typedef enum logic [1:0] {
        RAC_RATE_32K  = 2'h0,
        RAC_RATE_1024 = 2'h1,
        RAC_RATE_32   = 2'h2,
        RAC_RATE_1    = 2'h3
    } rac_rate_e;

endpackage : rac_pkg

/* File: verilog/rac_clock_output_pin_if.sv */
// Carrier between the register side and the clock-output generator
`timescale 1ns/1ps
`default_nettype none

interface rac_clock_output_pin_if;
    logic                osc_rise;
    logic                osc_fall;
    logic                osc_level;
    logic                enable;
    rac_pkg::rac_rate_e  rate_sel;
    logic                pin_level;
    logic                pin_oe;

    modport ctrl (
        output osc_rise,
        output osc_fall,
        output osc_level,
        output enable,
        output rate_sel,
        input  pin_level,
        input  pin_oe
    );

    modport gen (
        input  osc_rise,
        input  osc_fall,
        input  osc_level,
        input  enable,
        input  rate_sel,
        output pin_level,
        output pin_oe
    );
endinterface : rac_clock_output_pin_if

`default_nettype wire

/* File: verilog/rac_clock_output_pin_gen.sv */
// Clock-output generator: oscillator divider, glitch-free rate switch, pin driver
`timescale 1ns/1ps
`default_nettype none
`include "rac_defines.svh"

module rac_clock_output_pin_gen (
    // Clock, reset, enable
    input  wire logic     clk_in,
    input  wire logic     reset_in,
    input  wire logic     ce_in,
    // Link to register side
    rac_clock_output_pin_if.gen     bus
);

    logic [`RAC_DIV_W-1:0] div_r;
    rac_pkg::rac_rate_e    sel_r;
    logic                  pin_r;
    logic                  oe_r;
    logic                  src;
    logic                  safe_point;
    logic [3:0]            taps;

    // Divider advances on each oscillator rising edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_r <= '0;
        end else if (ce_in && bus.osc_rise) begin
            div_r <= div_r + 1'b1;
        end
    end

    // Old and new sources both low here, so a switch cannot cut a pulse short
    assign taps       = {div_r[`RAC_TAP_1HZ], div_r[`RAC_TAP_32HZ], div_r[`RAC_TAP_1024HZ],
                         bus.osc_level};
    assign safe_point = bus.osc_fall && !taps[sel_r] && !taps[bus.rate_sel];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sel_r <= rac_pkg::RAC_RATE_32K;
        end else if (ce_in && safe_point) begin
            sel_r <= bus.rate_sel;
        end
    end

    always_comb begin
        case (sel_r)
            rac_pkg::RAC_RATE_32K:  src = bus.osc_level;
            rac_pkg::RAC_RATE_1024: src = div_r[`RAC_TAP_1024HZ];
            rac_pkg::RAC_RATE_32:   src = div_r[`RAC_TAP_32HZ];
            rac_pkg::RAC_RATE_1:    src = div_r[`RAC_TAP_1HZ];
            default:                src = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pin_r <= 1'b0;
            oe_r  <= 1'b0;
        end else if (ce_in) begin
            pin_r <= bus.enable ? src : 1'b0;
            oe_r  <= bus.enable;
        end
    end

    assign bus.pin_level = pin_r;
    assign bus.pin_oe    = oe_r;

    rate_1hz_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $past(ce_in) && $past(bus.enable) && $past(sel_r) == rac_pkg::RAC_RATE_1
        |-> pin_r == $past(div_r[`RAC_TAP_1HZ]))
        else $error("1 Hz output does not follow divider tap");

    rate_1024_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $past(ce_in) && $past(bus.enable) && $past(sel_r) == rac_pkg::RAC_RATE_1024
        |-> pin_r == $past(div_r[`RAC_TAP_1024HZ]))
        else $error("1024 Hz output does not follow divider tap");

    switch_safe_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $changed(sel_r) |-> !pin_r && !src)
        else $error("Rate switched while a source was high");

endmodule : rac_clock_output_pin_gen

`default_nettype wire

/* File: verilog/rac_alarm_clock_output_pin.sv */
// Calendar year/month registers, alarm comparator and programmable clock output
//
// What this block does
// - Month register: BCD month in bits 4..0, century in bit 7, 6..5 unused.
// - Year register at 08H holds a two-digit BCD year in all eight bits.
// - Enabled alarm fields compare against the matching running-time field.
// - Alarm flag sets when all enabled comparisons first become true together.
// - Alarm flag stays set until software clears it.
// - After clearing, only a fresh time advance into a match, or a newly appearing match, sets it again.
// - Alarm registers with disable bit 1 are excluded from the match.
// - Minute alarm at 09H: bit 7 active-low enable, bits 6..0 BCD minute.
// - Hour alarm at 0AH: bit 7 active-low enable, bits 5..0 BCD hour.
// - Day alarm at 0BH: bit 7 active-low enable, bits 5..0 BCD day.
// - Weekday alarm: bit 7 active-low enable, bits 2..0 weekday 0..6.
// - Clock-output control bit 7 at 0DH low stops the pin, high impedance.
// - Enable bit high drives the selected frequency on the clock-output pin.
// - Rate select 00/01/10/11 gives 32.768 kHz, 1024 Hz, 32 Hz, 1 Hz.
`timescale 1ns/1ps
`default_nettype none
`include "rac_defines.svh"

module rac_alarm_clock_output_pin (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        ce_in,
    // Register access from the serial-bus slave
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    // Running time from the time-keeping counters
    input  wire logic [6:0]  cur_minute_in,
    input  wire logic [5:0]  cur_hour_in,
    input  wire logic [5:0]  cur_day_in,
    input  wire logic [2:0]  cur_weekday_in,
    // Alarm flag
    input  wire logic        alarm_flag_clear_in,
    output logic             alarm_match_flag_out,
    // Oscillator and clock-output pin
    input  wire logic        osc_in,
    output logic             clock_output_pin_out,
    output logic             clock_output_pin_oe_out
);

    // Register file
    logic [7:0] month_r;
    logic [7:0] year_count_r;
    logic [7:0] minute_alarm_r;
    logic [7:0] hour_alarm_r;
    logic [7:0] day_alarm_r;
    logic [7:0] weekday_alarm_r;
    logic [7:0] clock_output_control_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       wr_en;

    // Alarm state
    logic [6:0] prev_minute_r;
    logic [5:0] prev_hour_r;
    logic [5:0] prev_day_r;
    logic [2:0] prev_weekday_r;
    logic       match_prev_r;
    logic       alarm_match_flag_r;
    logic       min_hit;
    logic       hour_hit;
    logic       day_hit;
    logic       wday_hit;
    logic       any_enabled;
    logic       alarm_match;
    logic       time_changed;
    logic       alarm_set;

    // Oscillator synchroniser
    logic       osc_meta_r;
    logic       osc_sync_r;
    logic       osc_prev_r;

    rac_clock_output_pin_if clk_bus ();

    assign wr_en = ce_in && reg_wr_in;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            month_r                <= `RAC_MONTH_RESET;
            year_count_r           <= `RAC_YEAR_RESET;
            minute_alarm_r         <= `RAC_ALARM_RESET;
            hour_alarm_r           <= `RAC_ALARM_RESET;
            day_alarm_r            <= `RAC_ALARM_RESET;
            weekday_alarm_r        <= `RAC_ALARM_RESET;
            clock_output_control_r <= `RAC_CLK_CTRL_RESET;
        end else if (wr_en) begin
            case (reg_addr_in)
                `RAC_ADDR_MONTH:      month_r                <= reg_wdata_in & `RAC_MONTH_MASK;
                `RAC_ADDR_YEAR:       year_count_r           <= reg_wdata_in & `RAC_YEAR_MASK;
                `RAC_ADDR_MIN_ALARM:  minute_alarm_r         <= reg_wdata_in & `RAC_MIN_MASK;
                `RAC_ADDR_HOUR_ALARM: hour_alarm_r           <= reg_wdata_in & `RAC_HOUR_MASK;
                `RAC_ADDR_DAY_ALARM:  day_alarm_r            <= reg_wdata_in & `RAC_DAY_MASK;
                `RAC_ADDR_WDAY_ALARM: weekday_alarm_r        <= reg_wdata_in & `RAC_WDAY_MASK;
                `RAC_ADDR_CLK_CTRL:   clock_output_control_r <= reg_wdata_in & `RAC_CLK_CTRL_MASK;
                default:              month_r                <= month_r;
            endcase
        end
    end

    // Read data; unmapped offsets read zero
    always_comb begin
        case (reg_addr_in)
            `RAC_ADDR_MONTH:      rdata_nxt = month_r;
            `RAC_ADDR_YEAR:       rdata_nxt = year_count_r;
            `RAC_ADDR_MIN_ALARM:  rdata_nxt = minute_alarm_r;
            `RAC_ADDR_HOUR_ALARM: rdata_nxt = hour_alarm_r;
            `RAC_ADDR_DAY_ALARM:  rdata_nxt = day_alarm_r;
            `RAC_ADDR_WDAY_ALARM: rdata_nxt = weekday_alarm_r;
            `RAC_ADDR_CLK_CTRL:   rdata_nxt = clock_output_control_r;
            default:              rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_r <= 8'h00;
        end else if (ce_in) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    // Field comparisons; a disabled field counts as a hit
    assign min_hit  = minute_alarm_r[`RAC_ALARM_DIS_BIT]
                      || (minute_alarm_r[6:0] == cur_minute_in);
    assign hour_hit = hour_alarm_r[`RAC_ALARM_DIS_BIT]
                      || (hour_alarm_r[5:0] == cur_hour_in);
    assign day_hit  = day_alarm_r[`RAC_ALARM_DIS_BIT]
                      || (day_alarm_r[5:0] == cur_day_in);
    assign wday_hit = weekday_alarm_r[`RAC_ALARM_DIS_BIT]
                      || (weekday_alarm_r[2:0] == cur_weekday_in);

    // With every field disabled there is nothing to match
    assign any_enabled = !(minute_alarm_r[`RAC_ALARM_DIS_BIT]
                           && hour_alarm_r[`RAC_ALARM_DIS_BIT]
                           && day_alarm_r[`RAC_ALARM_DIS_BIT]
                           && weekday_alarm_r[`RAC_ALARM_DIS_BIT]);

    assign alarm_match = any_enabled && min_hit && hour_hit && day_hit && wday_hit;

    assign time_changed = (cur_minute_in  != prev_minute_r)
                       || (cur_hour_in    != prev_hour_r)
                       || (cur_day_in     != prev_day_r)
                       || (cur_weekday_in != prev_weekday_r);

    // Fresh match: time just advanced into it, or the match just appeared
    assign alarm_set = alarm_match && (time_changed || !match_prev_r);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prev_minute_r  <= 7'h00;
            prev_hour_r    <= 6'h00;
            prev_day_r     <= 6'h00;
            prev_weekday_r <= 3'h0;
            match_prev_r   <= 1'b0;
        end else if (ce_in) begin
            prev_minute_r  <= cur_minute_in;
            prev_hour_r    <= cur_hour_in;
            prev_day_r     <= cur_day_in;
            prev_weekday_r <= cur_weekday_in;
            match_prev_r   <= alarm_match;
        end
    end

    // Sticky flag; a set in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            alarm_match_flag_r <= 1'b0;
        end else if (ce_in) begin
            if (alarm_set) begin
                alarm_match_flag_r <= 1'b1;
            end else if (alarm_flag_clear_in) begin
                alarm_match_flag_r <= 1'b0;
            end
        end
    end

    assign alarm_match_flag_out = alarm_match_flag_r;

    // Oscillator crosses into clk_in through two flip-flops
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else if (ce_in) begin
            osc_meta_r <= osc_in;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    assign clk_bus.osc_rise  = osc_sync_r && !osc_prev_r;
    assign clk_bus.osc_fall  = !osc_sync_r && osc_prev_r;
    assign clk_bus.osc_level = osc_sync_r;
    assign clk_bus.enable    = clock_output_control_r[`RAC_CLK_EN_BIT];
    assign clk_bus.rate_sel  = rac_pkg::rac_rate_e'(clock_output_control_r[1:0]);

    rac_clock_output_pin_gen u_clock_output_pin_gen (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .bus      (clk_bus.gen)
    );

    // Pin level is forced low while undriven
    assign clock_output_pin_out    = clk_bus.pin_level;
    assign clock_output_pin_oe_out = clk_bus.pin_oe;

    month_write_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        wr_en && reg_addr_in == `RAC_ADDR_MONTH
        |=> month_r == {$past(reg_wdata_in[7]), 2'h0, $past(reg_wdata_in[4:0])})
        else $error("Month register did not store century and BCD month");

    year_write_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        wr_en && reg_addr_in == `RAC_ADDR_YEAR
        ##1 ce_in && !reg_wr_in && reg_addr_in == `RAC_ADDR_YEAR
        |=> reg_rdata_out == $past(year_count_r, 1) && year_count_r == $past(reg_wdata_in, 2))
        else $error("Year write not read back");

    field_miss_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !hour_alarm_r[`RAC_ALARM_DIS_BIT] && hour_alarm_r[5:0] != cur_hour_in
        |-> !alarm_match)
        else $error("Enabled hour mismatch still matched");

    flag_set_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && alarm_match && !match_prev_r |=> alarm_match_flag_out)
        else $error("Alarm flag not set on first match");

    flag_hold_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        alarm_match_flag_out && !(ce_in && alarm_flag_clear_in) |=> alarm_match_flag_out)
        else $error("Alarm flag dropped without a clear");

    no_reset_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && alarm_flag_clear_in && alarm_match && match_prev_r && !time_changed
        ##1 ce_in && alarm_match && !time_changed
        |-> !alarm_match_flag_r ##1 !alarm_match_flag_r)
        else $error("Persisting match set the flag again");

    disabled_ignored_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !any_enabled |-> !alarm_match ##1 !$rose(alarm_match_flag_r) || $past(alarm_set))
        else $error("Alarm matched with every field disabled");

    minute_field_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        minute_alarm_r[`RAC_ALARM_DIS_BIT] |-> min_hit)
        else $error("Disabled minute alarm was compared");

    hour_mask_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        hour_alarm_r[6] == 1'b0 && day_alarm_r[6] == 1'b0)
        else $error("Unused hour or day alarm bit set");

    wday_mask_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        weekday_alarm_r[6:3] == 4'h0)
        else $error("Unused weekday alarm bits set");

    pin_hiz_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && !clock_output_control_r[`RAC_CLK_EN_BIT]
        |=> !clock_output_pin_oe_out && !clock_output_pin_out)
        else $error("Clock output driven while disabled");

    pin_drive_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && clock_output_control_r[`RAC_CLK_EN_BIT] |=> clock_output_pin_oe_out)
        else $error("Clock output not driven while enabled");

    flag_timely_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && alarm_match && time_changed |=> alarm_match_flag_out)
        else $error("Time advance into match did not set the flag");

    flag_clear_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && alarm_flag_clear_in && !alarm_set |=> !alarm_match_flag_out)
        else $error("Alarm flag not cleared by software");

    set_wins_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ce_in && alarm_set && alarm_flag_clear_in |=> alarm_match_flag_out)
        else $error("Clear in the set cycle dropped the alarm flag");

    ce_freeze_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !ce_in |=> $stable(year_count_r) && $stable(alarm_match_flag_r) && $stable(rdata_r))
        else $error("State changed while the clock enable was low");

endmodule : rac_alarm_clock_output_pin

`default_nettype wire

/* File: test/rac_time_model.sv */
// Far-side model: crystal oscillator and running time counters
`timescale 1ns/1ps
`default_nettype none

module rac_time_model (
    // Oscillator
    output var logic       osc_out,
    // Running time, BCD
    output var logic [6:0] minute_out,
    output var logic [5:0] hour_out,
    output var logic [5:0] day_out,
    output var logic [2:0] weekday_out
);
    initial begin
        osc_out     = 1'b0;
        minute_out  = 7'h29;
        hour_out    = 6'h10;
        day_out     = 6'h15;
        weekday_out = 3'h3;
        // Offset so each oscillator edge falls 1 ns before a system clock rising edge
        #3;
        forever begin
            #40 osc_out = ~osc_out;
        end
    end

    // Caller changes time just after a system clock edge
    task automatic set_time(input logic [6:0] m, input logic [5:0] h,
                            input logic [5:0] d, input logic [2:0] w);
        minute_out  = m;
        hour_out    = h;
        day_out     = d;
        weekday_out = w;
    endtask : set_time
endmodule : rac_time_model

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the alarm and clock-output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
    logic       clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       ce_in = 1'b1;
    logic       reg_wr_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       alarm_flag_clear_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [6:0] cur_minute;
    logic [5:0] cur_hour;
    logic [5:0] cur_day;
    logic [2:0] cur_weekday;
    logic       osc;
    logic       alarm_match_flag_out;
    logic       clock_output_pin_out;
    logic       clock_output_pin_oe_out;
    int         n_fail = 0;
    int         checks_done = 0;

    always #4 clk_in = ~clk_in;

    rac_time_model rac_time_model_i (
        .osc_out     (osc),
        .minute_out  (cur_minute),
        .hour_out    (cur_hour),
        .day_out     (cur_day),
        .weekday_out (cur_weekday)
    );

    rac_alarm_clock_output_pin rac_alarm_clock_output_pin_i (
        .clk_in                  (clk_in),
        .reset_in                (reset_in),
        .ce_in                   (ce_in),
        .reg_wr_in               (reg_wr_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_rdata_out           (reg_rdata_out),
        .cur_minute_in           (cur_minute),
        .cur_hour_in             (cur_hour),
        .cur_day_in              (cur_day),
        .cur_weekday_in          (cur_weekday),
        .alarm_flag_clear_in     (alarm_flag_clear_in),
        .alarm_match_flag_out    (alarm_match_flag_out),
        .osc_in                  (osc),
        .clock_output_pin_out    (clock_output_pin_out),
        .clock_output_pin_oe_out (clock_output_pin_oe_out)
    );

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        step(1);
        reg_wr_in    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        step(1);
        reg_addr_in = a;
        step(1);
        d = reg_rdata_out;
    endtask : rd

    // Minute changes, other fields held at 10h, day 15, weekday 3
    task automatic at_minute(input logic [6:0] m);
        step(1);
        rac_time_model_i.set_time(m, 6'h10, 6'h15, 3'h3);
        step(2);
    endtask : at_minute

    task automatic clear_flag;
        step(1);
        alarm_flag_clear_in = 1'b1;
        step(1);
        alarm_flag_clear_in = 1'b0;
        step(1);
    endtask : clear_flag

    // Counts rising edges and the shortest high pulse wholly inside the window
    task automatic count_rises(input int cycles, output int n, output int hmin);
        logic last;
        int   run;
        n    = 0;
        hmin = cycles;
        run  = 0;
        last = clock_output_pin_out;
        repeat (cycles) begin
            step(1);
            if (clock_output_pin_out === 1'b1 && last === 1'b0) begin
                n++;
                run = 1;
            end else if (clock_output_pin_out === 1'b1 && run > 0) begin
                run++;
            end else if (clock_output_pin_out === 1'b0 && run > 0) begin
                hmin = (run < hmin) ? run : hmin;
                run  = 0;
            end
            last = clock_output_pin_out;
        end
    endtask : count_rises

    task automatic test_regs;
        logic [7:0] d;
        rd(8'h07, d); `CHK(d, 8'h01)
        rd(8'h08, d); `CHK(d, 8'h00)
        rd(8'h09, d); `CHK(d, 8'h80)
        rd(8'h0A, d); `CHK(d, 8'h80)
        rd(8'h0B, d); `CHK(d, 8'h80)
        rd(8'h0C, d); `CHK(d, 8'h80)
        rd(8'h0D, d); `CHK(d, 8'h80)
        rd(8'h0E, d); `CHK(d, 8'h00)
        // December with century set, then unused bits written high
        wr(8'h07, 8'h92); rd(8'h07, d); `CHK(d, 8'h92)
        wr(8'h07, 8'hFF); rd(8'h07, d); `CHK(d, 8'h9F)
        wr(8'h08, 8'h99); rd(8'h08, d); `CHK(d, 8'h99)
        ce_in = 1'b0; wr(8'h08, 8'h42); ce_in = 1'b1;
        rd(8'h08, d); `CHK(d, 8'h99)
        wr(8'h09, 8'hD9); rd(8'h09, d); `CHK(d, 8'hD9)
        wr(8'h0A, 8'hFF); rd(8'h0A, d); `CHK(d, 8'hBF)
        wr(8'h0B, 8'hFF); rd(8'h0B, d); `CHK(d, 8'hBF)
        wr(8'h0C, 8'hFF); rd(8'h0C, d); `CHK(d, 8'h87)
        wr(8'h0D, 8'hFF); rd(8'h0D, d); `CHK(d, 8'h83)
        wr(8'h0D, 8'h80);
        wr(8'h0E, 8'h55); rd(8'h0E, d); `CHK(d, 8'h00)
        wr(8'h09, 8'h80); wr(8'h0A, 8'h80); wr(8'h0B, 8'h80); wr(8'h0C, 8'h80);
    endtask : test_regs

    task automatic test_alarm;
        at_minute(7'h30); `CHK(alarm_match_flag_out, 1'b0)
        at_minute(7'h29); wr(8'h09, 8'h30); step(2);
        `CHK(alarm_match_flag_out, 1'b0)
        at_minute(7'h30); `CHK(alarm_match_flag_out, 1'b1)
        at_minute(7'h31); `CHK(alarm_match_flag_out, 1'b1)
        clear_flag;       `CHK(alarm_match_flag_out, 1'b0)
        at_minute(7'h30); `CHK(alarm_match_flag_out, 1'b1)
        clear_flag; step(5);
        `CHK(alarm_match_flag_out, 1'b0)
        // Clear in the very cycle the time enters the match: the set wins
        at_minute(7'h31); step(1);
        rac_time_model_i.set_time(7'h30, 6'h10, 6'h15, 3'h3);
        alarm_flag_clear_in = 1'b1;
        step(1);
        alarm_flag_clear_in = 1'b0;
        step(1);
        `CHK(alarm_match_flag_out, 1'b1)
        clear_flag;
        // Hour enabled but not matching blocks the minute match
        wr(8'h0A, 8'h11); at_minute(7'h31); at_minute(7'h30);
        `CHK(alarm_match_flag_out, 1'b0)
        wr(8'h0B, 8'h15); wr(8'h0C, 8'h03); wr(8'h0A, 8'h10); step(2);
        `CHK(alarm_match_flag_out, 1'b1)
        clear_flag;
        wr(8'h0C, 8'h04); at_minute(7'h31); at_minute(7'h30);
        `CHK(alarm_match_flag_out, 1'b0)
        wr(8'h0C, 8'h84); step(2);
        `CHK(alarm_match_flag_out, 1'b1)
        clear_flag;
        wr(8'h0B, 8'h16); at_minute(7'h31); at_minute(7'h30);
        `CHK(alarm_match_flag_out, 1'b0)
        wr(8'h09, 8'h80); wr(8'h0A, 8'h80); wr(8'h0B, 8'h80);
        at_minute(7'h31); at_minute(7'h30);
        `CHK(alarm_match_flag_out, 1'b0)
    endtask : test_alarm

    // A rate change waits until old and new sources are both low, at most about 170 cycles
    task automatic test_clock_output_pin;
        int n;
        int h;
        `CHK(clock_output_pin_oe_out, 1'b1)
        count_rises(1000, n, h);
        `CHK(n >= 99 && n <= 101, 1'b1)
        wr(8'h0D, 8'h81); count_rises(400, n, h);
        `CHK(h >= 4, 1'b1)
        count_rises(1000, n, h);
        `CHK(n >= 3 && n <= 4, 1'b1)
        wr(8'h0D, 8'h01); step(1);
        `CHK(clock_output_pin_oe_out, 1'b0)
        count_rises(200, n, h);
        `CHK(n, 0)
        `CHK(clock_output_pin_out, 1'b0)
        wr(8'h0D, 8'h81); step(1);
        `CHK(clock_output_pin_oe_out, 1'b1)
        count_rises(1000, n, h);
        `CHK(n >= 3 && n <= 4, 1'b1)
        // 1 Hz source stays low for far longer than this window
        wr(8'h0D, 8'h83); step(200); count_rises(400, n, h);
        `CHK(n, 0)
    endtask : test_clock_output_pin

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #60000;
        n_fail++;
        test_done;
    end

    initial begin
        step(20);
        reset_in = 1'b0;
        step(2);
        test_regs;
        test_clock_output_pin;
        test_alarm;
        test_done;
    end
endmodule : tb_top

`default_nettype wire
